// [hdl/sfwp_link_if.sv]
`timescale 1ns/1ps
interface sfwp_link_if;
	logic [7:0] rxByte;
	logic byteTgl;
	logic partial;
	logic [16:0] statusWord;
	logic dataOut;
	logic dataOeN;

	modport link(output rxByte, output byteTgl, output partial, output dataOut,
		output dataOeN, input statusWord);
	modport core(input rxByte, input byteTgl, input partial, input dataOut,
		input dataOeN, output statusWord);
endinterface : sfwp_link_if

// [hdl/sfwp_link_rx.sv]
`timescale 1ns/1ps
module sfwp_link_rx (
	// Link clock, frame and power-on reset
	input wire logic sclk,
	input wire logic csN,
	input wire logic rst,
	// Serial data in
	input wire logic di,
	// Carrier to the core
	sfwp_link_if.link lnk
);

	logic frameRst;
	logic [2:0] bitCntQ, bitCntD;
	logic [6:0] shiftQ, shiftD;
	logic gotOpQ, gotOpD;
	logic [1:0] readSelQ, readSelD;
	logic [7:0] rxByteQ, rxByteD;
	logic tglQ, tglD;
	logic partialQ, partialD;
	logic [16:0] statMetaQ, statQ;
	logic doQ, doD, doOeNQ, doOeND;
	logic byteDone;
	logic [7:0] fullByte;
	logic [7:0] word;

	// The clock stands still between frames, so frame state is cleared by chip select itself.
	assign frameRst = rst | csN;

	always_comb
	begin
		byteDone = (bitCntQ == 3'h7);
		fullByte = {shiftQ, di};
		bitCntD = bitCntQ + 3'h1;
		shiftD = fullByte[6:0];
		gotOpD = gotOpQ | byteDone;
		readSelD = readSelQ;
		if (byteDone && !gotOpQ)
		begin
			if (fullByte == sfwp_pkg::CmdReadLow)
				readSelD = 2'h1;
			else if (fullByte == sfwp_pkg::CmdReadHigh)
				readSelD = 2'h2;
		end
		rxByteD = byteDone ? fullByte : rxByteQ;
		tglD = tglQ ^ byteDone;
		partialD = !byteDone;
	end

	always_ff @(posedge sclk or posedge frameRst)
	begin
		if (frameRst)
		begin
			bitCntQ <= 3'h0;
			shiftQ <= 7'h00;
			gotOpQ <= 1'b0;
			readSelQ <= 2'h0;
		end
		else
		begin
			bitCntQ <= bitCntD;
			shiftQ <= shiftD;
			gotOpQ <= gotOpD;
			readSelQ <= readSelD;
		end
	end

	// Byte, toggle and partial flag outlive the frame so the core can judge its end.
	always_ff @(posedge sclk or posedge rst)
	begin
		if (rst)
		begin
			rxByteQ <= 8'h00;
			tglQ <= 1'b0;
			partialQ <= 1'b0;
			statMetaQ <= 17'h00000;
			statQ <= 17'h00000;
		end
		else
		begin
			rxByteQ <= rxByteD;
			tglQ <= tglD;
			partialQ <= partialD;
			statMetaQ <= lnk.statusWord;
			statQ <= statMetaQ;
		end
	end

	// Status reads are answered during busy but not in power-down.
	always_comb
	begin
		word = (readSelQ == 2'h2) ? statQ[15:8] : statQ[7:0];
		doD = word[3'h7 - bitCntQ];
		doOeND = !((readSelQ != 2'h0) && !statQ[16]);
	end

	always_ff @(negedge sclk or posedge frameRst)
	begin
		if (frameRst)
		begin
			doQ <= 1'b0;
			doOeNQ <= 1'b1;
		end
		else
		begin
			doQ <= doD;
			doOeNQ <= doOeND;
		end
	end

	assign lnk.rxByte = rxByteQ;
	assign lnk.byteTgl = tglQ;
	assign lnk.partial = partialQ;
	assign lnk.dataOut = doQ;
	assign lnk.dataOeN = doOeNQ;

endmodule : sfwp_link_rx

// [hdl/sfwp_pkg.sv]
package sfwp_pkg;

	// Instruction codes seen on the serial link.
	localparam logic [7:0] CmdWriteEnable = 8'h06;
	localparam logic [7:0] CmdWriteDisable = 8'h04;
	localparam logic [7:0] CmdReadLow = 8'h05;
	localparam logic [7:0] CmdReadHigh = 8'h35;
	localparam logic [7:0] CmdWriteStatus = 8'h01;
	localparam logic [7:0] CmdPageProgram = 8'h02;
	localparam logic [7:0] CmdQuadProgram = 8'h32;
	localparam logic [7:0] CmdBlockErase64 = 8'hD8;
	localparam logic [7:0] CmdBlockErase32 = 8'h52;
	localparam logic [7:0] CmdSectorErase = 8'h20;
	localparam logic [7:0] CmdChipEraseA = 8'hC7;
	localparam logic [7:0] CmdChipEraseB = 8'h60;
	localparam logic [7:0] CmdPowerDown = 8'hB9;
	localparam logic [7:0] CmdReleasePowerDown = 8'hAB;

	// Field positions in the low status word.
	localparam int BitBusy = 0;
	localparam int BitWriteLatch = 1;
	localparam int RegionLsb = 2;
	localparam int BitTopBottom = 5;
	localparam int BitGranularity = 6;
	localparam int BitLockLow = 7;
	// Field positions in the high status word.
	localparam int BitLockHigh = 0;
	localparam int BitQuadEnable = 1;

	// Values after reset, and lock-mode encodings.
	localparam logic [2:0] RegionReset = 3'h0;
	localparam logic [1:0] LockModeReset = 2'h0;
	localparam logic [1:0] LockModeSoftware = 2'h0;
	localparam logic [1:0] LockModeHardware = 2'h1;
	localparam logic [1:0] LockModePowerCycle = 2'h2;

	// Array geometry and frame byte counts.
	localparam int AddrBits = 21;
	localparam logic [2:0] AddrFrameBytes = 3'h4;
	localparam logic [2:0] StatusFrameBytes = 3'h2;

endpackage : sfwp_pkg

// [hdl/sfwp_status_core.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Held in reset, nothing runs and no instruction is recognised.
// - After power-up, write-type instructions are refused until a delay has elapsed.
// - Power-up leaves the write latch flag cleared.
// - Write enable sets the read-only write latch flag at status bit one.
// - Power-up and every write-type instruction clear the write latch flag.
// - Busy flag at bit zero is set while an operation runs, cleared after.
// - While busy, everything except status reads is ignored.
// - Region size bits are writable, default zero, and block writes in the region.
// - Top/bottom select anchors the region at top when zero, bottom when one.
// - Granularity bit selects 4KB sectors when one, 64KB blocks when zero.
// - Two lock-mode bits at positions eight and seven guard the status words.
// - Lock mode zero-zero ignores the protect pin; write latch alone permits.
// - Lock mode zero-one refuses status writes while the protect pin is low.
// - Lock mode one-zero refuses until power cycle, which restores zero-zero.
// - Lock mode one-one refuses every status write for good.
// - Quad enable defaults zero; when set, the protect pin is ignored and the extra data lines stay undriven.
// - In power-down only the release instruction is obeyed.
// - A write-type frame not ending on a byte boundary is dropped.
module sfwp_status_core #(
	parameter int PowerUpCycles = 1000,
	parameter int ProgCycles = 200,
	parameter int EraseCycles = 2000,
	parameter int StatusCycles = 500
) (
	// Core clock and power-on reset
	input wire logic core_clk,
	input wire logic rst,
	// Initialises the non-volatile fields only
	input wire logic factoryRst,
	// Serial link
	input wire logic sclk,
	input wire logic csN,
	input wire logic di,
	output logic doOut,
	output logic doOeN,
	// Protect pin, or third data line in quad mode
	input wire logic dataLineThreeIn,
	output logic dataLineThreeOut,
	output logic dataLineThreeOeN,
	// Pause pin, or fourth data line in quad mode
	input wire logic dataLineFourIn,
	output logic dataLineFourOut,
	output logic dataLineFourOeN
);

	localparam int CntW = 24;

	sfwp_link_if lnk ();

	sfwp_link_rx linkRx (
		.sclk(sclk),
		.csN(csN),
		.rst(rst),
		.di(di),
		.lnk(lnk.link)
	);

	// Protection check over the array; bits of the address below the region width do not matter.
	function automatic logic regionHit(input logic [2:0] size, input logic fromBottom,
		input logic sectors, input logic [sfwp_pkg::AddrBits-1:0] addr);
		logic [4:0] sh;
		logic [sfwp_pkg::AddrBits-1:0] probe;
		sh = sectors ? (size[2] ? 5'h0F : 5'h0B + {2'h0, size}) : 5'h0F + {2'h0, size};
		probe = fromBottom ? addr : ~addr;
		if (size == 3'h0)
			regionHit = 1'b0;
		else if (size[2:1] == 2'h3)
			regionHit = 1'b1;
		else
			regionHit = ((probe >> sh) == '0);
	endfunction : regionHit

	// Synchronisers into the core domain.
	logic [1:0] csSyncQ, tglSyncQ, partSyncQ, wpSyncQ;
	logic csPrevQ, tglPrevQ, frameEndQ, frameEndD;
	logic [2:0] byteCntQ, byteCntD;
	logic [7:0] opQ, opD, b1Q, b1D, b2Q, b2D, b3Q, b3D;
	logic byteEvt, csRise, csFall;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			csSyncQ <= 2'h3;
			tglSyncQ <= 2'h0;
			partSyncQ <= 2'h0;
			wpSyncQ <= 2'h3;
			csPrevQ <= 1'b1;
			tglPrevQ <= 1'b0;
		end
		else
		begin
			csSyncQ <= {csSyncQ[0], csN};
			tglSyncQ <= {tglSyncQ[0], lnk.byteTgl};
			partSyncQ <= {partSyncQ[0], lnk.partial};
			wpSyncQ <= {wpSyncQ[0], dataLineThreeIn};
			csPrevQ <= csSyncQ[1];
			tglPrevQ <= tglSyncQ[1];
		end
	end

	always_comb
	begin
		byteEvt = tglSyncQ[1] ^ tglPrevQ;
		csRise = csSyncQ[1] && !csPrevQ;
		csFall = !csSyncQ[1] && csPrevQ;
		byteCntD = byteCntQ;
		opD = opQ;
		b1D = b1Q;
		b2D = b2Q;
		b3D = b3Q;
		if (csFall)
			byteCntD = 3'h0;
		else if (byteEvt)
		begin
			unique case (byteCntQ)
				3'h0: opD = lnk.rxByte;
				3'h1: b1D = lnk.rxByte;
				3'h2: b2D = lnk.rxByte;
				3'h3: b3D = lnk.rxByte;
				default: ;
			endcase
			if (byteCntQ != 3'h7)
				byteCntD = byteCntQ + 3'h1;
		end
		// The end is acted on a cycle late so a last byte seen together with it is counted.
		frameEndD = csRise;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			byteCntQ <= 3'h0;
			opQ <= 8'h00;
			b1Q <= 8'h00;
			b2Q <= 8'h00;
			b3Q <= 8'h00;
			frameEndQ <= 1'b0;
		end
		else
		begin
			byteCntQ <= byteCntD;
			opQ <= opD;
			b1Q <= b1D;
			b2Q <= b2D;
			b3Q <= b3D;
			frameEndQ <= frameEndD;
		end
	end

	// Volatile control state.
	logic welQ, welD, busyQ, busyD, pdQ, pdD, freshQ;
	logic [CntW-1:0] busyCntQ, busyCntD, pupCntQ, pupCntD;
	// Non-volatile fields.
	logic [2:0] regionQ, regionD;
	logic topBotQ, topBotD, granQ, granD, quadEnQ, quadEnD;
	logic [1:0] lockModeQ, lockModeD;
	logic exec, pupHold, lockOpen, writeOp, hit, nvWrite;

	always_comb
	begin
		exec = frameEndQ && (byteCntQ != 3'h0);
		pupHold = (pupCntQ != '0);
		unique case (lockModeQ)
			sfwp_pkg::LockModeSoftware: lockOpen = 1'b1;
			sfwp_pkg::LockModeHardware: lockOpen = wpSyncQ[1] || quadEnQ;
			default: lockOpen = 1'b0;
		endcase
		writeOp = (opQ == sfwp_pkg::CmdPageProgram) || (opQ == sfwp_pkg::CmdQuadProgram)
			|| (opQ == sfwp_pkg::CmdBlockErase64) || (opQ == sfwp_pkg::CmdBlockErase32)
			|| (opQ == sfwp_pkg::CmdSectorErase);
		hit = regionHit(regionQ, topBotQ, granQ, {b1Q[4:0], b2Q, b3Q});
		welD = welQ;
		busyD = busyQ;
		pdD = pdQ;
		nvWrite = 1'b0;
		busyCntD = (busyCntQ != '0) ? busyCntQ - CntW'(1) : busyCntQ;
		pupCntD = pupHold ? pupCntQ - CntW'(1) : pupCntQ;
		if (busyQ && busyCntQ == CntW'(1))
			busyD = 1'b0;
		if (exec && !partSyncQ[1] && !busyQ)
		begin
			if (pdQ)
			begin
				if (opQ == sfwp_pkg::CmdReleasePowerDown)
					pdD = 1'b0;
			end
			else if (opQ == sfwp_pkg::CmdWriteEnable)
			begin
				if (!pupHold)
					welD = 1'b1;
			end
			else if (opQ == sfwp_pkg::CmdWriteDisable)
				welD = 1'b0;
			else if (opQ == sfwp_pkg::CmdPowerDown)
				pdD = 1'b1;
			else if (opQ == sfwp_pkg::CmdWriteStatus && welQ && !pupHold)
			begin
				welD = 1'b0;
				if (lockOpen && byteCntQ >= sfwp_pkg::StatusFrameBytes)
				begin
					nvWrite = 1'b1;
					busyD = 1'b1;
					busyCntD = CntW'(StatusCycles);
				end
			end
			else if (writeOp && welQ && !pupHold && byteCntQ >= sfwp_pkg::AddrFrameBytes)
			begin
				welD = 1'b0;
				if (!hit)
				begin
					busyD = 1'b1;
					busyCntD = (opQ == sfwp_pkg::CmdPageProgram || opQ == sfwp_pkg::CmdQuadProgram)
						? CntW'(ProgCycles) : CntW'(EraseCycles);
				end
			end
			else if ((opQ == sfwp_pkg::CmdChipEraseA || opQ == sfwp_pkg::CmdChipEraseB)
				&& welQ && !pupHold)
			begin
				welD = 1'b0;
				if (regionQ == sfwp_pkg::RegionReset)
				begin
					busyD = 1'b1;
					busyCntD = CntW'(EraseCycles);
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			welQ <= 1'b0;
			busyQ <= 1'b0;
			pdQ <= 1'b0;
			freshQ <= 1'b1;
			busyCntQ <= '0;
			pupCntQ <= CntW'(PowerUpCycles);
		end
		else
		begin
			welQ <= welD;
			busyQ <= busyD;
			pdQ <= pdD;
			freshQ <= 1'b0;
			busyCntQ <= busyCntD;
			pupCntQ <= pupCntD;
		end
	end

	// Non-volatile fields survive power-on reset; the first edge after it ends a power cycle.
	always_comb
	begin
		regionD = regionQ;
		topBotD = topBotQ;
		granD = granQ;
		quadEnD = quadEnQ;
		lockModeD = lockModeQ;
		if (rst)
			lockModeD = lockModeQ;
		else if (freshQ && lockModeQ == sfwp_pkg::LockModePowerCycle)
			lockModeD = sfwp_pkg::LockModeSoftware;
		else if (nvWrite)
		begin
			regionD = b1Q[sfwp_pkg::RegionLsb +: 3];
			topBotD = b1Q[sfwp_pkg::BitTopBottom];
			granD = b1Q[sfwp_pkg::BitGranularity];
			lockModeD = {b2Q[sfwp_pkg::BitLockHigh], b1Q[sfwp_pkg::BitLockLow]};
			quadEnD = b2Q[sfwp_pkg::BitQuadEnable];
		end
	end

	always_ff @(posedge core_clk or posedge factoryRst)
	begin
		if (factoryRst)
		begin
			regionQ <= sfwp_pkg::RegionReset;
			topBotQ <= 1'b0;
			granQ <= 1'b0;
			quadEnQ <= 1'b0;
			lockModeQ <= sfwp_pkg::LockModeReset;
		end
		else
		begin
			regionQ <= regionD;
			topBotQ <= topBotD;
			granQ <= granD;
			quadEnQ <= quadEnD;
			lockModeQ <= lockModeD;
		end
	end

	// Each bit crosses on its own, so the multi-bit region and lock-mode fields can arrive torn across the crossing.
	assign lnk.statusWord = {pdQ, 6'h00, quadEnQ, lockModeQ[1], lockModeQ[0], granQ, topBotQ,
		regionQ, welQ, busyQ};

	// Quad transfers are not served here; the extra data lines stay undriven.
	logic lineOeNQ;
	logic lineOutQ;
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			lineOeNQ <= 1'b1;
			lineOutQ <= 1'b0;
		end
		else
		begin
			lineOeNQ <= 1'b1;
			lineOutQ <= 1'b0;
		end
	end

	assign doOut = lnk.dataOut;
	assign doOeN = lnk.dataOeN;
	assign dataLineThreeOut = lineOutQ;
	assign dataLineFourOut = lineOutQ;
	assign dataLineThreeOeN = lineOeNQ;
	assign dataLineFourOeN = lineOeNQ;

	logic unusedPause;
	assign unusedPause = dataLineFourIn;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	latchPowerUp_a: assert property ($past(rst) |-> !welQ)
		else $error("Write latch set right after reset.");
	pupRefuse_a: assert property (exec && pupHold && !welQ |=> !welQ)
		else $error("Write enable taken during power-up delay.");
	enableSets_a: assert property (exec && !pdQ && !busyQ && !pupHold && !partSyncQ[1]
		&& opQ == sfwp_pkg::CmdWriteEnable |=> welQ)
		else $error("Write enable did not set the latch.");
	busyStart_a: assert property ($rose(busyQ) |-> !welQ ##1 busyQ)
		else $error("Busy began without clearing the latch.");
	busyEnd_a: assert property (busyQ && busyCntQ == CntW'(1) |=> !busyQ)
		else $error("Busy did not clear on completion.");
	busyIgnore_a: assert property (busyQ && busyCntQ != CntW'(1) |=> busyQ && $stable(pdQ))
		else $error("Instruction acted on while busy.");
	lockFixed_a: assert property (lockModeQ == 2'h3
		|=> $stable(regionQ) && lockModeQ == 2'h3)
		else $error("Status changed under permanent lock.");
	pinLock_a: assert property (lockModeQ == 2'h1 && !wpSyncQ[1] && !quadEnQ && !freshQ
		|=> $stable(regionQ) && $stable(quadEnQ))
		else $error("Status written with protect pin low.");
	partialDrop_a: assert property (exec && partSyncQ[1] && !busyQ
		|=> !busyQ && $stable(welQ))
		else $error("Unaligned frame was executed.");
	regionDrop_a: assert property (exec && !busyQ && !pdQ && writeOp && hit |=> !busyQ)
		else $error("Protected region was written.");
	sleepHold_a: assert property (pdQ && exec && opQ != sfwp_pkg::CmdReleasePowerDown
		|=> pdQ && $stable(welQ))
		else $error("Instruction obeyed in power-down.");

endmodule : sfwp_status_core

// [testbench/sfwp_host_model.sv]
`timescale 1ns/1ps
module sfwp_host_model (
	// Serial link driven by the host
	output logic sclk,
	output logic csN,
	output logic di,
	// Answer from the device
	input wire logic doOut,
	input wire logic doOeN
);
	logic lineQ;
	// Mode 0: the clock stands low and the select high between frames.
	initial
	begin
		sclk = 1'b0;
		csN = 1'b1;
		di = 1'b0;
		lineQ = 1'b0;
	end
	// Sends nBits from the top of data, MSB first; rd keeps the last eight bits seen.
	task automatic frame(input logic [31:0] data, input int nBits, output logic [7:0] rd);
		rd = 8'h00;
		csN = 1'b0;
		for (int i = 0; i < nBits; i++)
		begin
			di = data[31-i];
			#3;
			sclk = 1'b1;
			// A released line must not look like valid data, so it toggles.
			lineQ = doOeN ? ~lineQ : doOut;
			rd = {rd[6:0], lineQ};
			#3;
			sclk = 1'b0;
		end
		#3;
		csN = 1'b1;
		di = 1'b0;
		// The core needs a few of its cycles to see the end of the frame.
		#80;
	endtask : frame
endmodule : sfwp_host_model

// [testbench/sfwp_status_core_bench.sv]
`timescale 1ns/1ps
module sfwp_status_core_bench;
	logic core_clk;
	logic rst;
	logic factoryRst;
	logic sclk;
	logic csN;
	logic di;
	logic doOut;
	logic doOeN;
	logic dataLineThreeIn;
	logic dataLineThreeOeN;
	logic dataLineFourOeN;
	logic dataLineThreeOut;
	logic dataLineFourOut;
	logic dataLineFourIn;
	int num_errors;
	int num_checks;
	int cycles;
	logic [7:0] v;
	localparam logic [7:0] ProtLo [6] = '{8'h64, 8'h64, 8'h04, 8'h04, 8'h24, 8'h24};
	localparam logic [23:0] ProtAddr [6] = '{24'h000100, 24'h001000, 24'h1F0000,
		24'h0F0000, 24'h00FFFF, 24'h010000};

	sfwp_status_core #(.PowerUpCycles(20), .ProgCycles(40), .EraseCycles(80),
		.StatusCycles(80)) i_sfwp_status_core (
		.core_clk(core_clk), .rst(rst), .factoryRst(factoryRst), .sclk(sclk),
		.csN(csN), .di(di), .doOut(doOut), .doOeN(doOeN),
		.dataLineThreeIn(dataLineThreeIn), .dataLineThreeOut(dataLineThreeOut),
		.dataLineThreeOeN(dataLineThreeOeN), .dataLineFourIn(dataLineFourIn),
		.dataLineFourOut(dataLineFourOut), .dataLineFourOeN(dataLineFourOeN));

	sfwp_host_model i_sfwp_host_model (.sclk(sclk), .csN(csN), .di(di),
		.doOut(doOut), .doOeN(doOeN));

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] op);
		logic [7:0] rd;
		i_sfwp_host_model.frame({op, 24'h000000}, 8, rd);
	endtask : cmd

	task automatic rdSt(input logic [7:0] op, output logic [7:0] val);
		i_sfwp_host_model.frame({op, 24'h000000}, 16, val);
	endtask : rdSt

	task automatic wrSt(input logic [7:0] lo, input logic [7:0] hi, input int n);
		logic [7:0] rd;
		cmd(sfwp_pkg::CmdWriteEnable);
		i_sfwp_host_model.frame({sfwp_pkg::CmdWriteStatus, lo, hi, 8'h00}, n, rd);
	endtask : wrSt

	task automatic waitIdle;
		logic [7:0] val;
		val = 8'h01;
		for (int i = 0; i < 40 && val[0] !== 1'b0; i++)
			rdSt(sfwp_pkg::CmdReadLow, val);
	endtask : waitIdle

	task automatic expSt(input string what, input logic [7:0] lo, input logic [7:0] hi);
		logic [7:0] val;
		rdSt(sfwp_pkg::CmdReadLow, val);
		chk(what, val, lo);
		rdSt(sfwp_pkg::CmdReadHigh, val);
		chk(what, val, hi);
	endtask : expSt

	task automatic pwrCycle;
		@(negedge core_clk);
		rst = 1'b1;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
		repeat (30) @(negedge core_clk);
	endtask : pwrCycle

	// The protect pin is set high before the lock mode is written so that write lands.
	task automatic lockCase(input logic [7:0] sLo, input logic [7:0] sHi,
		input logic [7:0] tLo, input logic [7:0] tHi, input logic [7:0] eLo,
		input logic [7:0] eHi, input logic pin);
		@(negedge core_clk);
		dataLineThreeIn = 1'b1;
		repeat (4) @(negedge core_clk);
		wrSt(sLo, sHi, 24);
		waitIdle();
		@(negedge core_clk);
		dataLineThreeIn = pin;
		repeat (4) @(negedge core_clk);
		wrSt(tLo, tHi, 24);
		waitIdle();
		cmd(sfwp_pkg::CmdWriteDisable);
		expSt("lock mode", eLo, eHi);
	endtask : lockCase

	initial
	begin
		num_errors = 0;
		num_checks = 0;
		cycles = 0;
		rst = 1'b1;
		factoryRst = 1'b1;
		// The pause line is pulled high, not tied to a rail, since quad mode is set later.
		dataLineFourIn = 1'b1;
		dataLineThreeIn = 1'b1;
		repeat (12) @(negedge core_clk);
		chk("output enable in reset", {7'h00, doOeN}, 8'h01);
		rst = 1'b0;
		factoryRst = 1'b0;
		cmd(sfwp_pkg::CmdWriteEnable);
		expSt("early write enable", 8'h00, 8'h00);
		repeat (30) @(negedge core_clk);
		cmd(sfwp_pkg::CmdWriteEnable);
		expSt("write enable", 8'h02, 8'h00);
		cmd(sfwp_pkg::CmdWriteDisable);
		expSt("write disable", 8'h00, 8'h00);
		wrSt(8'h64, 8'h00, 23);
		expSt("partial frame", 8'h02, 8'h00);
		wrSt(8'h64, 8'h00, 24);
		rdSt(sfwp_pkg::CmdReadLow, v);
		chk("busy", v & 8'h01, 8'h01);
		// Ignored while busy, so the latch must stay clear afterwards.
		cmd(sfwp_pkg::CmdWriteEnable);
		waitIdle();
		expSt("status write", 8'h64, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			wrSt(ProtLo[i], 8'h00, 24);
			waitIdle();
			cmd(sfwp_pkg::CmdWriteEnable);
			i_sfwp_host_model.frame({sfwp_pkg::CmdSectorErase, ProtAddr[i]}, 32, v);
			rdSt(sfwp_pkg::CmdReadLow, v);
			chk("protected erase", v & 8'h01, (i % 2 == 1) ? 8'h01 : 8'h00);
			waitIdle();
			expSt("after erase", ProtLo[i], 8'h00);
		end
		lockCase(8'h00, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 1'b0);
		lockCase(8'h80, 8'h00, 8'h88, 8'h00, 8'h80, 8'h00, 1'b0);
		lockCase(8'h80, 8'h00, 8'h88, 8'h00, 8'h88, 8'h00, 1'b1);
		lockCase(8'h80, 8'h02, 8'h8C, 8'h02, 8'h8C, 8'h02, 1'b0);
		chk("extra lines released", {4'h0, dataLineThreeOeN, dataLineFourOeN, dataLineThreeOut,
			dataLineFourOut}, 8'h0C);
		lockCase(8'h00, 8'h01, 8'h04, 8'h01, 8'h00, 8'h01, 1'b1);
		pwrCycle();
		expSt("after power cycle", 8'h00, 8'h00);
		lockCase(8'h80, 8'h01, 8'h00, 8'h00, 8'h80, 8'h01, 1'b1);
		pwrCycle();
		expSt("permanent lock", 8'h80, 8'h01);
		cmd(sfwp_pkg::CmdPowerDown);
		cmd(sfwp_pkg::CmdWriteEnable);
		cmd(sfwp_pkg::CmdReleasePowerDown);
		expSt("power down", 8'h80, 8'h01);
		give_verdict();
	end
endmodule : sfwp_status_core_bench
